// file: hdl/sbcms_mode_fsm.sv
// sbcms_mode_fsm: operating-mode controller of the system basis chip
// assumes all inputs but reset_line_n_i synchronous to clk_i; analog detectors upstream
`timescale 1ns/1ps

// Behaviour
// RULE1 - battery loss forces Off, all disabled
// RULE2 - battery return: Standby with reset pulse
// RULE3 - Sleep wake-up: Standby, reset, code 00
// RULE4 - temperature recovery: Standby with reset pulse
// RULE5 - Normal to Standby on 00 or reset
// RULE6 - Standby: main regulator, transceivers lowpower/off
// RULE7 - Standby watchdog Timeout or Off
// RULE8 - codes 10/11 select Normal, can regulator
// RULE9 - code 01 requests Sleep
// RULE10 - overtemperature from Normal/Standby enters Overtemp
// RULE11 - Normal: can active or lowpower by bit
// RULE12 - Normal: each lin active or lowpower
// RULE13 - Sleep needs no interrupt, wake, source
// RULE14 - refused Sleep gives short reset pulse
// RULE15 - Sleep: regulators off, transceivers off/lowpower
// RULE16 - Sleep: watchdog stopped, reset low
// RULE17 - Overtemp: regulators off, buses high-resistive
// RULE18 - Overtemp entry: reset low, limp set
// RULE19 - watchdog mode control picks watchdog mode
// RULE20 - disable pin stops watchdog, software reset
// RULE21 - power-off beats every other trigger
module sbcms_mode_fsm #(
   parameter int SHORT_CYC = sbcms_pkg::SHORT_RST_CYC,
   parameter int LONG_CYC  = sbcms_pkg::LONG_RST_CYC
) (
   // clock, reset, enable
   input  wire logic       clk_i,
   input  wire logic       reset_line_n_i,
   input  wire logic       ce_i,
   // supply and temperature detectors
   input  wire logic       bat_poff_i,
   input  wire logic       bat_pon_i,
   input  wire logic       otp_act_i,
   input  wire logic       otp_rel_i,
   // host mode control
   input  wire logic       mode_wr_i,
   input  wire logic [1:0] mode_wdata_i,
   input  wire logic       long_rst_sel_i,
   input  wire logic       ext_reset_i,
   // configuration
   input  wire logic       can_lowpower_select_i,
   input  wire logic       lin1_lowpower_select_i,
   input  wire logic       lin2_lowpower_select_i,
   input  wire logic       watchdog_mode_control_i,
   input  wire logic       watchdog_disable_pin_i,
   // sleep entry conditions and wake-up event
   input  wire logic       interrupt_out_n_i,
   input  wire logic       wake_pending_i,
   input  wire logic       wake_src_en_i,
   input  wire logic       wake_event_i,
   // outputs
   output logic [4:0]      mode_o,
   output logic [1:0]      mode_select_field_o,
   output logic            main_regulator_o,
   output logic            can_regulator_o,
   output logic [1:0]      can_state_o,
   output logic [1:0]      lin1_state_o,
   output logic [1:0]      lin2_state_o,
   output logic [1:0]      wdog_state_o,
   output logic            watchdog_off_status_o,
   output logic            reset_line_n_o,
   output logic            limp_home_control_o,
   output logic            limp_n_o
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      sbcms_pkg::sbcms_mode_t            mode;
      logic [1:0]                        msel;
      logic                              v2;
      logic [sbcms_pkg::RST_CNT_W-1:0]   rcnt;
      logic                              limp_home_control;
      logic                              limp_n;
      logic                              wdis_q;
      logic                              main_reg;
      logic [1:0]                        can_st;
      logic [1:0]                        lin1_st;
      logic [1:0]                        lin2_st;
      logic [1:0]                        wd_st;
      logic                              rst_n;
   } sbcms_state_t;

   sbcms_state_t st;
   sbcms_state_t next_st;

   // pulse length for system resets triggered here
   function automatic logic [sbcms_pkg::RST_CNT_W-1:0] rst_len(
      input logic long_sel);
      rst_len = long_sel ? sbcms_pkg::RST_CNT_W'(LONG_CYC)
                         : sbcms_pkg::RST_CNT_W'(SHORT_CYC);
   endfunction

   // lowpower bit picks lowpower or the given other state
   function automatic logic [1:0] xcvr(input logic lp,
                                       input logic [1:0] other);
      xcvr = lp ? sbcms_pkg::XCVR_LOWPWR : other;
   endfunction

   logic sleep_ok;
   logic wd_kick;

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      // RULE13 sleep entry check
      sleep_ok = interrupt_out_n_i && !wake_pending_i && wake_src_en_i;
      wd_kick  = 1'b0;
      if (st.rcnt != '0)
      begin
         next_st.rcnt = st.rcnt - 1'b1;
      end
      next_st.wdis_q = watchdog_disable_pin_i;
      // RULE20 pin rise resets software
      if (watchdog_disable_pin_i && !st.wdis_q)
      begin
         wd_kick = 1'b1;
      end
      // RULE21 power-off first
      if (bat_poff_i)
      begin
         // RULE1 enter off
         next_st.mode = sbcms_pkg::SBCMS_OFF;
         next_st.rcnt = '0;
      end
      else
      begin
         unique case (st.mode)
            sbcms_pkg::SBCMS_OFF:
            begin
               // RULE2 power-on reset
               if (bat_pon_i)
               begin
                  next_st.mode = sbcms_pkg::SBCMS_STANDBY;
                  next_st.msel = sbcms_pkg::MSEL_STANDBY;
                  next_st.rcnt = rst_len(long_rst_sel_i);
               end
            end
            sbcms_pkg::SBCMS_STANDBY, sbcms_pkg::SBCMS_NORMAL:
            begin
               if (otp_act_i)
               begin
                  // RULE10 overtemperature
                  next_st.mode = sbcms_pkg::SBCMS_OVERTEMP;
                  // RULE18 limp set on entry
                  next_st.limp_home_control  = 1'b1;
               end
               else if (wd_kick || (ext_reset_i &&
                        st.mode == sbcms_pkg::SBCMS_NORMAL))
               begin
                  // RULE5 reset returns to standby
                  next_st.mode = sbcms_pkg::SBCMS_STANDBY;
                  next_st.msel = sbcms_pkg::MSEL_STANDBY;
                  if (wd_kick)
                  begin
                     next_st.rcnt = rst_len(long_rst_sel_i);
                  end
               end
               else if (mode_wr_i)
               begin
                  next_st.msel = mode_wdata_i;
                  unique case (mode_wdata_i)
                     // RULE5 host standby
                     sbcms_pkg::MSEL_STANDBY:
                        next_st.mode = sbcms_pkg::SBCMS_STANDBY;
                     // RULE9 sleep request
                     sbcms_pkg::MSEL_SLEEP:
                     begin
                        if (sleep_ok)
                        begin
                           next_st.mode = sbcms_pkg::SBCMS_SLEEP;
                        end
                        else
                        begin
                           // RULE14 refused, short reset
                           next_st.msel = st.msel;
                           next_st.rcnt = sbcms_pkg::RST_CNT_W'(SHORT_CYC);
                        end
                     end
                     default:
                     begin
                        // RULE8 normal, can regulator by code
                        next_st.mode = sbcms_pkg::SBCMS_NORMAL;
                        next_st.v2   = mode_wdata_i[0];
                     end
                  endcase
               end
            end
            sbcms_pkg::SBCMS_SLEEP:
            begin
               // RULE3 wake to standby
               if (wake_event_i)
               begin
                  next_st.mode = sbcms_pkg::SBCMS_STANDBY;
                  next_st.msel = sbcms_pkg::MSEL_STANDBY;
                  next_st.rcnt = rst_len(long_rst_sel_i);
               end
            end
            sbcms_pkg::SBCMS_OVERTEMP:
            begin
               // RULE4 hysteresis release
               if (otp_rel_i)
               begin
                  next_st.mode = sbcms_pkg::SBCMS_STANDBY;
                  next_st.msel = sbcms_pkg::MSEL_STANDBY;
                  next_st.rcnt = rst_len(long_rst_sel_i);
               end
            end
            default:
               next_st.mode = sbcms_pkg::SBCMS_OFF;
         endcase
      end
      // can regulator flag only lives in normal, so its output is a flop
      if (next_st.mode != sbcms_pkg::SBCMS_NORMAL)
      begin
         next_st.v2 = 1'b0;
      end
      // RULE18 limp pin low while control bit set
      next_st.limp_n = !next_st.limp_home_control;
      // outputs decoded from the next mode so they stay registered
      next_st.main_reg = 1'b0;
      next_st.can_st   = sbcms_pkg::XCVR_OFF;
      next_st.lin1_st  = sbcms_pkg::XCVR_OFF;
      next_st.lin2_st  = sbcms_pkg::XCVR_OFF;
      next_st.wd_st    = sbcms_pkg::WDOG_OFF;
      next_st.rst_n    = (next_st.rcnt == '0);
      unique case (next_st.mode)
         sbcms_pkg::SBCMS_STANDBY:
         begin
            // RULE6 standby supplies
            next_st.main_reg = 1'b1;
            next_st.can_st   = xcvr(can_lowpower_select_i,
                                    sbcms_pkg::XCVR_OFF);
            next_st.lin1_st  = xcvr(lin1_lowpower_select_i,
                                    sbcms_pkg::XCVR_OFF);
            next_st.lin2_st  = xcvr(lin2_lowpower_select_i,
                                    sbcms_pkg::XCVR_OFF);
            // RULE7 standby watchdog
            // RULE19 control bit choice
            next_st.wd_st = watchdog_mode_control_i ?
                            sbcms_pkg::WDOG_OFF : sbcms_pkg::WDOG_TIMEOUT;
         end
         sbcms_pkg::SBCMS_NORMAL:
         begin
            next_st.main_reg = 1'b1;
            // RULE11 can by bit
            next_st.can_st  = xcvr(can_lowpower_select_i,
                                   sbcms_pkg::XCVR_ACTIVE);
            // RULE12 each lin by bit
            next_st.lin1_st = xcvr(lin1_lowpower_select_i,
                                   sbcms_pkg::XCVR_ACTIVE);
            next_st.lin2_st = xcvr(lin2_lowpower_select_i,
                                   sbcms_pkg::XCVR_ACTIVE);
            // RULE19 control bit choice
            next_st.wd_st = watchdog_mode_control_i ?
                            sbcms_pkg::WDOG_TIMEOUT : sbcms_pkg::WDOG_WINDOW;
         end
         sbcms_pkg::SBCMS_SLEEP:
         begin
            // RULE15 sleep transceivers
            next_st.can_st  = xcvr(can_lowpower_select_i,
                                   sbcms_pkg::XCVR_OFF);
            next_st.lin1_st = xcvr(lin1_lowpower_select_i,
                                   sbcms_pkg::XCVR_OFF);
            next_st.lin2_st = xcvr(lin2_lowpower_select_i,
                                   sbcms_pkg::XCVR_OFF);
            // RULE16 reset held low
            next_st.rst_n   = 1'b0;
         end
         // RULE17 overtemp all off
         // RULE18 reset low in overtemp
         sbcms_pkg::SBCMS_OVERTEMP:
            next_st.rst_n = 1'b0;
         // RULE1 off keeps all disabled
         sbcms_pkg::SBCMS_OFF:
            next_st.rst_n = 1'b0;
         default:
            next_st.rst_n = 1'b0;
      endcase
      // RULE20 pin overrides watchdog
      if (watchdog_disable_pin_i)
      begin
         next_st.wd_st = sbcms_pkg::WDOG_OFF;
      end
   end

   // -----------------------------------------------------------------
   // state register; ce_i freezes everything
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_line_n_i)
   begin
      if (!reset_line_n_i)
      begin
         st        <= '0;
         st.mode   <= sbcms_pkg::SBCMS_OFF;
         st.limp_n <= 1'b1;
      end
      else if (ce_i)
      begin
         st <= next_st;
      end
   end

   // outputs straight from flip-flops
   assign mode_o                = st.mode;
   assign mode_select_field_o   = st.msel;
   assign main_regulator_o      = st.main_reg;
   assign can_regulator_o       = st.v2;
   assign can_state_o           = st.can_st;
   assign lin1_state_o          = st.lin1_st;
   assign lin2_state_o          = st.lin2_st;
   assign wdog_state_o          = st.wd_st;
   assign watchdog_off_status_o = st.wdis_q;
   assign reset_line_n_o        = st.rst_n;
   assign limp_home_control_o   = st.limp_home_control;
   assign limp_n_o              = st.limp_n; // own flop, limp active low

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_line_n_i);

   sequence s_poff; ce_i && bat_poff_i; endsequence
   AST_POFF: assert property (s_poff |=> mode_o == sbcms_pkg::SBCMS_OFF) // RULE1 RULE21
      else $error("power-off did not force off mode");
   AST_OFF_REGS: assert property (mode_o == sbcms_pkg::SBCMS_OFF
      |-> !main_regulator_o && can_state_o == sbcms_pkg::XCVR_OFF) // RULE1
      else $error("off mode left something enabled");
   AST_PON: assert property (ce_i && !bat_poff_i && bat_pon_i &&
      mode_o == sbcms_pkg::SBCMS_OFF |=> mode_o == sbcms_pkg::SBCMS_STANDBY
      && !reset_line_n_o) // RULE2
      else $error("power-on did not reach standby with reset");
   AST_WAKE: assert property (ce_i && !bat_poff_i && wake_event_i &&
      mode_o == sbcms_pkg::SBCMS_SLEEP |=> mode_o == sbcms_pkg::SBCMS_STANDBY
      && mode_select_field_o == 2'h0 && main_regulator_o) // RULE3
      else $error("wake-up from sleep mishandled");
   AST_OT_EXIT: assert property (ce_i && !bat_poff_i && otp_rel_i &&
      mode_o == sbcms_pkg::SBCMS_OVERTEMP |=>
      mode_o == sbcms_pkg::SBCMS_STANDBY) // RULE4
      else $error("overtemp release not taken");
   AST_OT_ENTRY: assert property (ce_i && !bat_poff_i && otp_act_i &&
      (mode_o == sbcms_pkg::SBCMS_NORMAL ||
       mode_o == sbcms_pkg::SBCMS_STANDBY) |=>
      mode_o == sbcms_pkg::SBCMS_OVERTEMP && !reset_line_n_o &&
      limp_home_control_o && !main_regulator_o) // RULE10 RULE17 RULE18
      else $error("overtemp entry wrong");
   AST_SLEEP_OUT: assert property (mode_o == sbcms_pkg::SBCMS_SLEEP |->
      !main_regulator_o && !can_regulator_o && !reset_line_n_o &&
      wdog_state_o == sbcms_pkg::WDOG_OFF) // RULE15 RULE16
      else $error("sleep mode outputs wrong");
   sequence s_refuse;
      ce_i && !bat_poff_i && !otp_act_i && !watchdog_disable_pin_i &&
      !ext_reset_i && mode_wr_i && mode_wdata_i == 2'h1 && !sleep_ok &&
      mode_o == sbcms_pkg::SBCMS_STANDBY;
   endsequence
   AST_REFUSE: assert property (s_refuse |=> !reset_line_n_o &&
      mode_o == sbcms_pkg::SBCMS_STANDBY ##1 !reset_line_n_o) // RULE14 RULE13
      else $error("refused sleep did not give reset");
   AST_NORMAL: assert property (ce_i && !bat_poff_i && !otp_act_i &&
      !watchdog_disable_pin_i && mode_wr_i && mode_wdata_i == 2'h3 &&
      mode_o == sbcms_pkg::SBCMS_STANDBY |=>
      mode_o == sbcms_pkg::SBCMS_NORMAL && can_regulator_o) // RULE8
      else $error("normal selection failed");
   AST_WDIS: assert property (ce_i && watchdog_disable_pin_i |=>
      wdog_state_o == sbcms_pkg::WDOG_OFF) // RULE20 RULE7
      else $error("watchdog not stopped by disable pin");

endmodule

// file: hdl/sbcms_pkg.sv
// sbcms_pkg: constants and types of the operating-mode state machine
// assumes a 100 MHz system clock feeding the controller
package sbcms_pkg;

   // -----------------------------------------------------------------
   // mode-select codes written by the host
   // -----------------------------------------------------------------
   localparam logic [1:0] MSEL_STANDBY   = 2'h0;
   localparam logic [1:0] MSEL_SLEEP     = 2'h1;
   localparam logic [1:0] MSEL_NORMAL_NC = 2'h2; // can regulator off
   localparam logic [1:0] MSEL_NORMAL_C  = 2'h3; // can regulator on

   // -----------------------------------------------------------------
   // transceiver power states
   // -----------------------------------------------------------------
   localparam logic [1:0] XCVR_OFF    = 2'h0; // high-resistive
   localparam logic [1:0] XCVR_LOWPWR = 2'h1; // wake-up detection
   localparam logic [1:0] XCVR_ACTIVE = 2'h2;

   // -----------------------------------------------------------------
   // watchdog states
   // -----------------------------------------------------------------
   localparam logic [1:0] WDOG_OFF     = 2'h0;
   localparam logic [1:0] WDOG_TIMEOUT = 2'h1;
   localparam logic [1:0] WDOG_WINDOW  = 2'h2;

   // -----------------------------------------------------------------
   // reset pulse timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int SHORT_RST_US     = 3600; // 3.6 ms least width
   localparam int SHORT_RST_CYC    =
      (SHORT_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LONG_RST_US      = 40000; // plain default
   localparam int LONG_RST_CYC     =
      (LONG_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W        = 24;

   // -----------------------------------------------------------------
   // operating modes, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      SBCMS_OFF      = 5'h01,
      SBCMS_STANDBY  = 5'h02,
      SBCMS_NORMAL   = 5'h04,
      SBCMS_SLEEP    = 5'h08,
      SBCMS_OVERTEMP = 5'h10
   } sbcms_mode_t;

endpackage

// file: verification/sbcms_host_model.sv
// sbcms_host_model: host side of the mode controller, writes mode codes
// assumes the bench calls its tasks; drives only off the falling edge
`timescale 1ns/1ps

module sbcms_host_model (
   // clock
   input  wire logic       clk_i,
   // mode control towards the controller
   output logic            mode_wr_o,
   output logic [1:0]      mode_wdata_o,
   output logic            ext_reset_o
);
   // -----------------------------------------------------------------
   // idle levels
   // -----------------------------------------------------------------
   initial
   begin
      mode_wr_o    = 1'b0;
      mode_wdata_o = 2'h0;
      ext_reset_o  = 1'b0;
   end

   // one-cycle code write
   // data is flipped after the strobe so a stale code is never reused
   task automatic write_mode(input logic [1:0] code);
      @(negedge clk_i);
      mode_wr_o    = 1'b1;
      mode_wdata_o = code;
      @(negedge clk_i);
      mode_wr_o    = 1'b0;
      mode_wdata_o = ~code;
   endtask

   // system reset request seen by the controller for one cycle
   task automatic sys_reset();
      @(negedge clk_i);
      ext_reset_o = 1'b1;
      @(negedge clk_i);
      ext_reset_o = 1'b0;
   endtask
endmodule

// file: verification/tb_sbcms_mode_fsm.sv
// tb_sbcms_mode_fsm: self-checking bench of the operating-mode controller
// assumes short and long reset pulses shrunk to 8 and 16 cycles for simulation
`timescale 1ns/1ps

module tb_sbcms_mode_fsm;
   localparam int SC = 8;
   localparam int LC = 16;
   logic clk = 1'b0, reset_line_n = 1'b0, ce = 1'b1, poff = 1'b0, pon = 1'b0;
   logic ota = 1'b0, otr = 1'b0, lsel = 1'b0, clp = 1'b0, l1lp = 1'b0;
   logic l2lp = 1'b0, watchdog_mode_control = 1'b0, watchdog_disable_pin = 1'b0, interrupt_out_n = 1'b1;
   logic wpend = 1'b0, wsrc = 1'b1, wev = 1'b0, wr, xrst;
   logic [1:0] wdata, msel, cst, l1st, l2st, wst;
   logic [4:0] mode;
   logic mreg, creg, wos, rst_n, limp, limp_n;
   logic [16:0] obs;
   int num_errors = 0, total_checks = 0;

   // -----------------------------------------------------------------
   // clock, parts
   // -----------------------------------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end
   assign obs = {mode, msel, mreg, creg, cst, l1st, l2st, wst};

   sbcms_host_model i_sbcms_host_model (.clk_i(clk), .mode_wr_o(wr),
      .mode_wdata_o(wdata), .ext_reset_o(xrst));

   sbcms_mode_fsm #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_sbcms_mode_fsm (
      .clk_i(clk), .reset_line_n_i(reset_line_n), .ce_i(ce), .bat_poff_i(poff),
      .bat_pon_i(pon), .otp_act_i(ota), .otp_rel_i(otr), .mode_wr_i(wr),
      .mode_wdata_i(wdata), .long_rst_sel_i(lsel), .ext_reset_i(xrst),
      .can_lowpower_select_i(clp), .lin1_lowpower_select_i(l1lp),
      .lin2_lowpower_select_i(l2lp), .watchdog_mode_control_i(watchdog_mode_control),
      .watchdog_disable_pin_i(watchdog_disable_pin), .interrupt_out_n_i(interrupt_out_n),
      .wake_pending_i(wpend), .wake_src_en_i(wsrc), .wake_event_i(wev),
      .mode_o(mode), .mode_select_field_o(msel), .main_regulator_o(mreg),
      .can_regulator_o(creg), .can_state_o(cst), .lin1_state_o(l1st),
      .lin2_state_o(l2st), .wdog_state_o(wst),
      .watchdog_off_status_o(wos), .reset_line_n_o(rst_n),
      .limp_home_control_o(limp), .limp_n_o(limp_n));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [16:0] ev(input logic [4:0] m,
      input logic [1:0] s, input logic mr, input logic cr,
      input logic [1:0] c, input logic [1:0] l1, input logic [1:0] l2,
      input logic [1:0] w);
      return {m, s, mr, cr, c, l1, l2, w};
   endfunction

   task automatic tick();
      @(negedge clk);
   endtask

   // bounded wait for the reset line to rise; returns low cycles seen
   task automatic settle(output int c);
      c = 0;
      while (rst_n !== 1'b1 && c < 100)
      begin
         tick();
         c++;
      end
   endtask

   // the pulse length may be one cycle short or up to two cycles long from sampling alignment
   task automatic wait_rst(input int n);
      int c;
      settle(c);
      check(17'(c >= n - 1 && c <= n + 2), 17'h1);
   endtask

   // regulators off and every transceiver high-resistive, reset low
   task automatic chk_dark(input logic [4:0] m);
      check(17'(mode), 17'(m));
      check(17'({mreg, creg, cst, l1st, l2st}), 17'h0);
      check(17'(rst_n), 17'h0);
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_power_up();
      tick();
      chk_dark(sbcms_pkg::SBCMS_OFF);
      pon = 1'b1;
      tick();
      tick();
      check(obs, ev(sbcms_pkg::SBCMS_STANDBY, 0, 1, 0, 0, 0, 0, 1));
      wait_rst(SC);
      $display("test power_up done");
   endtask

   task automatic t_normal();
      int c;
      l1lp = 1'b1;
      i_sbcms_host_model.write_mode(2'h3);
      check(obs, ev(sbcms_pkg::SBCMS_NORMAL, 3, 1, 1, 2, 1, 2, 2));
      watchdog_mode_control = 1'b1;
      tick();
      check(17'(wst), 17'(sbcms_pkg::WDOG_TIMEOUT));
      watchdog_mode_control = 1'b0;
      i_sbcms_host_model.write_mode(2'h0);
      check(obs, ev(sbcms_pkg::SBCMS_STANDBY, 0, 1, 0, 0, 1, 0, 1));
      clp = 1'b1;
      i_sbcms_host_model.write_mode(2'h2);
      check(obs, ev(sbcms_pkg::SBCMS_NORMAL, 2, 1, 0, 1, 1, 2, 2));
      i_sbcms_host_model.sys_reset();
      check(17'(mode), 17'(sbcms_pkg::SBCMS_STANDBY));
      settle(c);
      $display("test normal done");
   endtask

   task automatic t_sleep();
      for (int i = 0; i < 3; i++)
      begin
         interrupt_out_n  = (i != 0);
         wpend = (i == 1);
         wsrc  = (i != 2);
         i_sbcms_host_model.write_mode(2'h1);
         check(17'({mode, msel}), 17'({sbcms_pkg::SBCMS_STANDBY, 2'h0}));
         check(17'(rst_n), 17'h0);
         wait_rst(SC);
      end
      {interrupt_out_n, wpend, wsrc} = 3'h5;
      i_sbcms_host_model.write_mode(2'h1);
      check(obs, ev(sbcms_pkg::SBCMS_SLEEP, 1, 0, 0, 1, 1, 0, 0));
      i_sbcms_host_model.write_mode(2'h3);
      check(17'({mode, rst_n}), 17'({sbcms_pkg::SBCMS_SLEEP, 1'b0}));
      wev = 1'b1;
      tick();
      wev = 1'b0;
      tick();
      check(obs, ev(sbcms_pkg::SBCMS_STANDBY, 0, 1, 0, 1, 1, 0, 1));
      wait_rst(SC);
      $display("test sleep done");
   endtask

   task automatic t_otemp();
      i_sbcms_host_model.write_mode(2'h3);
      ota = 1'b1;
      tick();
      tick();
      chk_dark(sbcms_pkg::SBCMS_OVERTEMP);
      check(17'({limp, limp_n}), 17'h2);
      ota = 1'b0;
      tick();
      tick();
      check(17'(mode), 17'(sbcms_pkg::SBCMS_OVERTEMP));
      otr  = 1'b1;
      lsel = 1'b1;
      tick();
      tick();
      check(17'(mode), 17'(sbcms_pkg::SBCMS_STANDBY));
      otr = 1'b0;
      wait_rst(LC);
      lsel = 1'b0;
      $display("test overtemp done");
   endtask

   task automatic t_wdog();
      watchdog_mode_control = 1'b1;
      tick();
      tick();
      check(17'(wst), 17'(sbcms_pkg::WDOG_OFF));
      watchdog_mode_control = 1'b0;
      i_sbcms_host_model.write_mode(2'h3);
      watchdog_disable_pin = 1'b1;
      tick();
      tick();
      check(17'({mode, wst, wos}), 17'({sbcms_pkg::SBCMS_STANDBY, 3'h1}));
      wait_rst(SC);
      watchdog_disable_pin = 1'b0;
      tick();
      tick();
      check(17'({wst, wos}), 17'h2);
      $display("test watchdog done");
   endtask

   task automatic t_freeze();
      l2lp = 1'b1;
      i_sbcms_host_model.write_mode(2'h3);
      check(obs, ev(sbcms_pkg::SBCMS_NORMAL, 3, 1, 1, 1, 1, 1, 2));
      ce = 1'b0;
      i_sbcms_host_model.write_mode(2'h0);
      check(17'(mode), 17'(sbcms_pkg::SBCMS_NORMAL));
      ce   = 1'b1;
      l2lp = 1'b0;
      $display("test freeze done");
   endtask

   task automatic t_poff();
      i_sbcms_host_model.write_mode(2'h3);
      fork
         i_sbcms_host_model.write_mode(2'h0);
         begin
            tick();
            {poff, pon, ota} = 3'h5;
         end
      join
      tick();
      chk_dark(sbcms_pkg::SBCMS_OFF);
      $display("test power_off done");
   endtask

   // -----------------------------------------------------------------
   // verdict, main sequence, watchdog
   // -----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (10) tick();
      reset_line_n = 1'b1;
      t_power_up();
      t_normal();
      t_sleep();
      t_otemp();
      t_wdog();
      t_freeze();
      t_poff();
      conclude();
   end

   // the tests need some 120 cycles; a hang is cut well beyond that
   initial
   begin
      #100000;
      num_errors++;
      conclude();
   end
endmodule
